// ### fifo_host_pkg.sv
// Constants, field layout and carrier types for the strobe-driven FIFO host
package fifo_host_pkg;

  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_NS      = 5;
  localparam int STROBE_NS   = 50;
  localparam int RECOVER_NS  = 30;
  localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
                               (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOVER_CYC = (RECOVER_NS + CLK_NS - 1) / CLK_NS < 1 ? 1 :
                               (RECOVER_NS + CLK_NS - 1) / CLK_NS;

  // ****************************************
  // Device shape
  // ****************************************
  localparam int FIFO_WORDS = 16384;
  localparam int WORD_W     = 9;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [4:0] CTRL_ADDR   = 5'h00;
  localparam logic [4:0] CMD_ADDR    = 5'h04;
  localparam logic [4:0] WDATA_ADDR  = 5'h08;
  localparam logic [4:0] RDATA_ADDR  = 5'h0c;
  localparam logic [4:0] STATUS_ADDR = 5'h10;

  localparam int CTRL_LOAD_BIT    = 9;
  localparam int CMD_RESET_BIT    = 0;
  localparam int CMD_REPLAY_BIT   = 1;
  localparam int ST_BUSY_BIT      = 0;
  localparam int ST_EMPTY_BIT     = 1;
  localparam int ST_FULL_BIT      = 2;
  localparam int ST_FILL_BIT      = 3;
  localparam int ST_REFUSED_BIT   = 4;

  localparam logic [9:0] CTRL_RESET = 10'h100;

  // ****************************************
  // Types
  // ****************************************
  typedef struct packed {
    logic clear_n;
    logic write_n;
    logic read_n;
    logic replay_n;
  } strobe_type;

  localparam strobe_type STROBE_IDLE = 4'hf;

  typedef enum logic [2:0] {
    S_IDLE, S_RST_A, S_RST_LOAD, S_RST_B, S_WRITE, S_READ, S_REPLAY, S_RECOVER
  } state_type;

endpackage : fifo_host_pkg

// ### fifo_host.sv
// Host controller driving one FIFO or a depth chain of FIFOs through their pins
`timescale 1ns/1ps
module fifo_host #(
  parameter int DEVICES = 1,
  parameter int DATA_W  = fifo_host_pkg::WORD_W
) (
  // Clock, reset, enable
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic                ce,
  // Avalon-MM slave
  input  wire logic [4:0]          address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [31:0]         writedata,
  output logic      [31:0]         readdata,
  output logic                     waitrequest,
  // FIFO pins, shared controls
  output logic      [DATA_W-1:0]   data_in_bus,
  output logic                     write_strobe_n,
  output logic                     read_strobe_n,
  output logic                     clear_input_n,
  input  wire logic [DATA_W-1:0]   data_out_bus,
  // FIFO pins, one per device
  input  wire logic [DEVICES-1:0]  nothing_stored_n,
  input  wire logic [DEVICES-1:0]  no_room_n,
  input  wire logic [DEVICES-1:0]  chain_out_n,
  output logic      [DEVICES-1:0]  chain_in_n,
  output logic      [DEVICES-1:0]  first_in_chain_n
);

  localparam int  SW     = DATA_W + 3 * DEVICES;
  localparam bit  SINGLE = (DEVICES == 1);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [SW-1:0] s1_reg;
  logic [SW-1:0] s2_reg;
  logic [SW-1:0] s3_reg;
  logic [SW-1:0] stable_reg;
  logic [SW-1:0] stable_next;
  wire  [SW-1:0] pins_raw = {data_out_bus, nothing_stored_n, no_room_n, chain_out_n};

  // Change counts once second and third stage agree
  assign stable_next = (s2_reg == s3_reg) ? s3_reg : stable_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s1_reg     <= '1;
      s2_reg     <= '1;
      s3_reg     <= '1;
      stable_reg <= '1;
    end else if (ce) begin
      s1_reg     <= pins_raw;
      s2_reg     <= s1_reg;
      s3_reg     <= s2_reg;
      stable_reg <= stable_next;
    end
  end

  wire [DATA_W-1:0]  q_st     = stable_reg[SW-1 -: DATA_W];
  wire [DEVICES-1:0] empty_st = stable_reg[3*DEVICES-1 -: DEVICES];
  wire [DEVICES-1:0] full_st  = stable_reg[2*DEVICES-1 -: DEVICES];
  wire [DEVICES-1:0] fill_st  = stable_reg[DEVICES-1:0];

  // composite flags, low only when all low
  wire comp_empty_n = |empty_st;
  wire comp_full_n  = |full_st;
  // fill flag absent in a chain
  wire fill_n       = SINGLE ? fill_st[0] : 1'b1;

  // ****************************************
  // Chain wiring
  // ****************************************
  fifo_host_pkg::strobe_type strobe_reg;
  fifo_host_pkg::strobe_type strobe_next;

  genvar gi;
  generate
    for (gi = 0; gi < DEVICES; gi++) begin : g_chain
      if (SINGLE) begin : g_single
        assign chain_in_n[gi]       = 1'b0;
        assign first_in_chain_n[gi] = strobe_reg.replay_n;
      end else begin : g_depth
        // expansion output feeds the next device
        assign chain_in_n[gi]       = chain_out_n[(gi + DEVICES - 1) % DEVICES];
        assign first_in_chain_n[gi] = (gi != 0);
      end
    end
  endgenerate

  // ****************************************
  // Register bus decode
  // ****************************************
  fifo_host_pkg::state_type state_reg;
  fifo_host_pkg::state_type state_next;
  logic [9:0]        ctrl_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic              refused_reg;
  logic              rack_reg;
  logic [31:0]       readdata_reg;

  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    hit = (a == off);
  endfunction : hit

  wire hit_ctrl   = hit(address, fifo_host_pkg::CTRL_ADDR);
  wire hit_cmd    = hit(address, fifo_host_pkg::CMD_ADDR);
  wire hit_wdata  = hit(address, fifo_host_pkg::WDATA_ADDR);
  wire hit_rdata  = hit(address, fifo_host_pkg::RDATA_ADDR);
  wire hit_status = hit(address, fifo_host_pkg::STATUS_ADDR);
  wire busy       = (state_reg != fifo_host_pkg::S_IDLE);

  // Commands wait for the sequencer; registers never stall a write
  assign waitrequest = (write & busy & (hit_cmd | hit_wdata | hit_rdata)) |
                       (read & ~rack_reg);

  wire wr_take    = write & ~waitrequest;
  wire cmd_reset  = wr_take & hit_cmd & writedata[fifo_host_pkg::CMD_RESET_BIT];
  wire cmd_replay = wr_take & hit_cmd & writedata[fifo_host_pkg::CMD_REPLAY_BIT] & ~cmd_reset;
  // write strobe only while room remains
  wire go_write   = wr_take & hit_wdata & comp_full_n;
  // read strobe only while data stored
  wire go_read    = wr_take & hit_rdata & comp_empty_n;
  wire go_replay  = cmd_replay & SINGLE;
  wire refuse_evt = (wr_take & hit_wdata & ~comp_full_n) |
                    (wr_take & hit_rdata & ~comp_empty_n) | (cmd_replay & ~SINGLE);
  wire refuse_clr = wr_take & hit_status & writedata[fifo_host_pkg::ST_REFUSED_BIT];
  // New refusal wins over a clear in the same cycle
  wire refused_next = refuse_evt | (refused_reg & ~refuse_clr);

  wire [31:0] status_word = {27'h0, refused_reg, fill_n, comp_full_n, comp_empty_n, busy};
  wire [31:0] rd_mux = hit_ctrl   ? {22'h0, ctrl_reg} :
                       hit_rdata  ? {{(32 - DATA_W){1'b0}}, rdata_reg} :
                       hit_status ? status_word : 32'h0;
  assign readdata = readdata_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_reg     <= fifo_host_pkg::CTRL_RESET;
      refused_reg  <= 1'b0;
      rack_reg     <= 1'b0;
      readdata_reg <= 32'h0;
    end else if (ce) begin
      if (wr_take & hit_ctrl) begin
        ctrl_reg <= writedata[9:0];
      end
      refused_reg  <= refused_next;
      rack_reg     <= read & ~rack_reg;
      readdata_reg <= (read & ~rack_reg) ? rd_mux : readdata_reg;
    end
  end

  // ****************************************
  // Strobe sequencer
  // ****************************************
  logic [7:0]        cnt_reg;
  logic [7:0]        cnt_next;
  logic [DATA_W-1:0] din_reg;
  wire               cnt_done = (cnt_reg == 8'h0);
  wire [7:0]         strobe_len  = 8'(fifo_host_pkg::STROBE_CYC - 1);
  wire [7:0]         recover_len = 8'(fifo_host_pkg::RECOVER_CYC - 1);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_done ? cnt_reg : cnt_reg - 8'h1;
    case (state_reg)
      fifo_host_pkg::S_IDLE: begin
        cnt_next = strobe_len;
        if (cmd_reset) begin
          state_next = fifo_host_pkg::S_RST_A;
        end else if (go_write) begin
          state_next = fifo_host_pkg::S_WRITE;
        end else if (go_read) begin
          state_next = fifo_host_pkg::S_READ;
        end else if (go_replay) begin
          state_next = fifo_host_pkg::S_REPLAY;
        end
      end
      fifo_host_pkg::S_RST_A: begin
        if (cnt_done) begin
          cnt_next   = strobe_len;
          state_next = ctrl_reg[fifo_host_pkg::CTRL_LOAD_BIT] ? fifo_host_pkg::S_RST_LOAD
                                                              : fifo_host_pkg::S_RST_B;
        end
      end
      fifo_host_pkg::S_RST_LOAD: begin
        if (cnt_done) begin
          cnt_next   = strobe_len;
          state_next = fifo_host_pkg::S_RST_B;
        end
      end
      fifo_host_pkg::S_RST_B, fifo_host_pkg::S_WRITE, fifo_host_pkg::S_READ,
      fifo_host_pkg::S_REPLAY: begin
        if (cnt_done) begin
          cnt_next   = recover_len;
          state_next = fifo_host_pkg::S_RECOVER;
        end
      end
      fifo_host_pkg::S_RECOVER: begin
        if (cnt_done) begin
          state_next = fifo_host_pkg::S_IDLE;
        end
      end
      default: begin
        state_next = fifo_host_pkg::S_IDLE;
      end
    endcase
  end

  // Strobes follow the next state so they change with the state itself
  wire in_rst_next = (state_next == fifo_host_pkg::S_RST_A) |
                     (state_next == fifo_host_pkg::S_RST_LOAD) |
                     (state_next == fifo_host_pkg::S_RST_B);
  assign strobe_next.clear_n  = ~in_rst_next;
  // offset loaded by write pulse inside reset
  assign strobe_next.write_n  = ~((state_next == fifo_host_pkg::S_WRITE) |
                                  (state_next == fifo_host_pkg::S_RST_LOAD));
  assign strobe_next.read_n   = ~(state_next == fifo_host_pkg::S_READ);
  assign strobe_next.replay_n = ~(state_next == fifo_host_pkg::S_REPLAY);

  // offset code on the data pins during reset load
  wire [DATA_W-1:0] din_next =
    (state_reg == fifo_host_pkg::S_IDLE && go_write) ? writedata[DATA_W-1:0] :
    (state_next == fifo_host_pkg::S_RST_LOAD)        ? ctrl_reg[DATA_W-1:0] : din_reg;
  // Data captured at strobe end, after access time and sync delay
  wire capture = (state_reg == fifo_host_pkg::S_READ) & cnt_done;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_reg  <= fifo_host_pkg::S_IDLE;
      cnt_reg    <= 8'h0;
      strobe_reg <= fifo_host_pkg::STROBE_IDLE;
      din_reg    <= '0;
      rdata_reg  <= '0;
    end else if (ce) begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      strobe_reg <= strobe_next;
      din_reg    <= din_next;
      rdata_reg  <= capture ? q_st : rdata_reg;
    end
  end

  // one strobe set shared by all
  assign data_in_bus    = din_reg;
  assign write_strobe_n = strobe_reg.write_n;
  assign read_strobe_n  = strobe_reg.read_n;
  assign clear_input_n  = strobe_reg.clear_n;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst || !ce);

  sequence s_load_pulse;
    (!write_strobe_n && !clear_input_n)[*8];
  endsequence

  a_write_guard: assert property ($fell(write_strobe_n) && clear_input_n |-> $past(comp_full_n))
    else $error("write strobe started while full");
  a_write_width: assert property ($fell(write_strobe_n) |-> (!write_strobe_n)[*8])
    else $error("write strobe too short");
  a_read_guard: assert property ($fell(read_strobe_n) |-> $past(comp_empty_n))
    else $error("read strobe started while empty");
  a_offset_load: assert property ($fell(write_strobe_n) && !clear_input_n
                                  |-> data_in_bus == ctrl_reg[DATA_W-1:0] ##0 s_load_pulse)
    else $error("offset load not held inside reset");
  a_empty_refusal: assert property (wr_take && hit_rdata && !comp_empty_n
                                    |=> refused_reg && read_strobe_n)
    else $error("read strobe issued on composite empty");
  a_fill_status: assert property (read && rack_reg && $past(hit_status)
                                  |-> readdata[fifo_host_pkg::ST_FILL_BIT] == $past(fill_n))
    else $error("fill status read back wrong");
  a_chain_first: assert property (!SINGLE |-> first_in_chain_n == DEVICES'(~1))
    else $error("first load marking wrong");
  a_chain_link: assert property (!SINGLE |-> chain_in_n[DEVICES-1] == chain_out_n[DEVICES-2 < 0 ? 0 : DEVICES-2])
    else $error("expansion link broken");

endmodule : fifo_host

// ### fifo_device_model.sv
// Behavioural model of the strobe-driven FIFO device facing the host
`timescale 1ns/1ps
module fifo_device_model #(
  parameter int DEPTH = 16,
  parameter int UNIT  = 32
) (
  // Control strobes
  input  wire logic       clear_input_n,
  input  wire logic       write_strobe_n,
  input  wire logic       read_strobe_n,
  input  wire logic       replay_request_n,
  input  wire logic       chain_in_n,
  // Data
  input  wire logic [8:0] data_in_bus,
  output logic      [8:0] data_out_bus,
  // Flags
  output logic            nothing_stored_n,
  output logic            no_room_n,
  output logic            chain_out_n
);
  logic [8:0] mem [DEPTH];
  logic [8:0] last   = 9'h000;
  int         wp     = 0;
  int         rp     = 0;
  int         offset = DEPTH / 2;

  // ****************************************
  // Pointers
  // ****************************************
  // reset and default offset
  always @(negedge clear_input_n) begin
    wp = 0;
    rp = 0;
    offset = DEPTH / 2;
  end
  always @(negedge write_strobe_n) begin
    // Data and strobe leave the host on one edge; let the data settle
    #1;
    if (!clear_input_n) offset = data_in_bus * UNIT;
    else if (wp - rp < DEPTH) begin
      mem[wp % DEPTH] = data_in_bus;
      wp++;
    end
  end
  always @(negedge read_strobe_n) begin
    if (clear_input_n && wp != rp) begin
      last = mem[rp % DEPTH];
      rp++;
    end
  end
  always @(negedge replay_request_n) begin
    if (!chain_in_n && clear_input_n) rp = 0;
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Released bus shows inverse so a stale sample cannot pass
  // word stands while strobe low
  assign data_out_bus     = read_strobe_n ? ~last : last;
  assign nothing_stored_n = wp != rp;
  assign no_room_n        = (wp - rp) != DEPTH;
  assign chain_out_n      = chain_in_n ? 1'b1 : ((wp - rp) <= offset);
endmodule : fifo_device_model

// ### fifo_host_bench.sv
// Self-checking bench for the FIFO host controller with a device model
`timescale 1ns/1ps
`define CHK(g, e) check_val(32'(g), 32'(e))
module fifo_host_bench;
  localparam int DEPTH = 16;
  logic        clk = 1'b0, sys_rst = 1'b1, ce = 1'b1, read = 1'b0, write = 1'b0;
  logic [4:0]  address = 5'h00;
  logic [31:0] writedata = 32'h0, readdata, rd;
  logic        waitrequest, write_strobe_n, read_strobe_n, clear_input_n;
  logic [8:0]  data_in_bus, data_out_bus, h[$], q[$];
  logic [0:0]  nothing_stored_n, no_room_n, chain_out_n, chain_in_n, first_in_chain_n;
  int          miscompares = 0, compares = 0, cnt = 0, off = 8;
  integer      seed = 32'hfbdf2ad9;

  fifo_host u_fifo_host (.clk, .sys_rst, .ce, .address, .read, .write, .writedata,
    .readdata, .waitrequest, .data_in_bus, .write_strobe_n, .read_strobe_n,
    .clear_input_n, .data_out_bus, .nothing_stored_n, .no_room_n, .chain_out_n,
    .chain_in_n, .first_in_chain_n);
  fifo_device_model #(.DEPTH(DEPTH), .UNIT(1)) u_fifo_device_model (.clear_input_n,
    .write_strobe_n, .read_strobe_n, .replay_request_n(first_in_chain_n[0]),
    .chain_in_n(chain_in_n[0]), .data_in_bus, .data_out_bus,
    .nothing_stored_n(nothing_stored_n[0]), .no_room_n(no_room_n[0]),
    .chain_out_n(chain_out_n[0]));

  initial forever #2.5 clk = ~clk;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic give_verdict;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic check_val(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check_val

  function automatic logic [3:0] exp_flags(input int c, input int o);
    return {c <= o, c != DEPTH, c != 0, 1'b0};
  endfunction : exp_flags

  // One Avalon transfer; wr high means write
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    // Waitrequest and read data taken at the same rising edge
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 1000);
    if (n >= 1000) begin
      miscompares++;
      give_verdict;
    end
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask : bus

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, fifo_host_pkg::STATUS_ADDR, 32'h0);
      n++;
    end while (rd[fifo_host_pkg::ST_BUSY_BIT] !== 1'b0 && n < 100);
    if (n >= 100) begin
      miscompares++;
      give_verdict;
    end
  endtask : wait_idle

  task automatic reset_fifo(input logic [9:0] c);
    bus(1'b1, fifo_host_pkg::CTRL_ADDR, 32'(c));
    bus(1'b1, fifo_host_pkg::CMD_ADDR, 32'h1);
    wait_idle;
    cnt = 0;
    q.delete();
    off = c[9] ? int'(c[8:0]) : DEPTH / 2;
  endtask : reset_fifo

  task automatic push(input logic [8:0] w);
    bus(1'b1, fifo_host_pkg::WDATA_ADDR, 32'(w));
    wait_idle;
    if (cnt < DEPTH) begin
      q.push_back(w);
      cnt++;
    end
  endtask : push

  task automatic pop;
    bus(1'b1, fifo_host_pkg::RDATA_ADDR, 32'h0);
    wait_idle;
    bus(1'b0, fifo_host_pkg::RDATA_ADDR, 32'h0);
    if (cnt > 0) begin
      `CHK(rd, q.pop_front());
      cnt--;
    end
  endtask : pop

  task automatic chk_status(input logic rf);
    bus(1'b0, fifo_host_pkg::STATUS_ADDR, 32'h0);
    `CHK(rd & 32'h1f, {rf, exp_flags(cnt, off)});
  endtask : chk_status

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    bus(1'b0, fifo_host_pkg::CTRL_ADDR, 32'h0);
    `CHK(rd, fifo_host_pkg::CTRL_RESET);
    bus(1'b0, 5'h1c, 32'h0);
    `CHK(rd, 32'h0);
    reset_fifo(10'h000);
    chk_status(1'b0);
    repeat (5) push(9'($random(seed)));
    repeat (5) pop;
    pop;
    chk_status(1'b1);
    bus(1'b1, fifo_host_pkg::STATUS_ADDR, 32'h10);
    chk_status(1'b0);
    $display("test traffic done");
    repeat (DEPTH) push(9'($random(seed)));
    chk_status(1'b0);
    push(9'h1aa);
    chk_status(1'b1);
    bus(1'b1, fifo_host_pkg::STATUS_ADDR, 32'h10);
    pop;
    push(9'h155);
    chk_status(1'b0);
    repeat (DEPTH) pop;
    $display("test full done");
    for (int i = 0; i < 3; i++) begin
      reset_fifo({1'b1, 9'(i * 3)});
      repeat (off + 1) push(9'($random(seed)));
      chk_status(1'b0);
      pop;
      chk_status(1'b0);
    end
    reset_fifo(10'h000);
    repeat (off + 1) push(9'($random(seed)));
    chk_status(1'b0);
    $display("test offset done");
    reset_fifo(10'h000);
    repeat (3) push(9'($random(seed)));
    h = q;
    repeat (2) pop;
    bus(1'b1, fifo_host_pkg::CMD_ADDR, 32'h2);
    // Freeze mid-replay; the pops below show nothing was lost
    ce <= 1'b0;
    repeat (8) @(posedge clk);
    ce <= 1'b1;
    wait_idle;
    q = h;
    cnt = 3;
    repeat (3) pop;
    chk_status(1'b0);
    $display("test replay done");
    give_verdict;
  end
endmodule : fifo_host_bench
